/* bench/scan_host.sv */
// test controller model driving the scan pins
`timescale 1ns/1ns
module scan_host (
   output scan_pkg::scan_pins_s pins,
   input  wire logic            tdo,
   input  wire logic            tdo_oe
);
   logic lb = 1'b0;
   initial pins = '{1'b0, 1'b1, 1'b0, 1'b0};
   task automatic rst_pin(input logic v);
      pins.trst_n = v;
   endtask
   // one tck period, tms and tdi steady round the rise
   task automatic tick(input logic ms, input logic di, output logic b);
      pins.tms = ms;
      pins.tdi = di;
      #8 pins.tck = 1'b1;
      #15 lb = tdo_oe ? tdo : ~lb;
      b = lb;
      #1 pins.tck = 1'b0;
      #8;
   endtask
   task automatic to_idle();
      logic b;
      repeat (5) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   endtask
   // scan from idle back to idle, lsb first
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic b;
      dout = '0;
      tick(1'b1, 1'b0, b);
      if (ir) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], b);
         dout[i] = b;
      end
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   endtask
endmodule

/* bench/scan_port_chk.sv */
// assertions on the scan test port pins
`timescale 1ns/1ns
module scan_port_chk #(
   parameter int BSR_LEN = 8
) (
   input wire logic               clk,
   input wire logic               rst_n,
   input scan_pkg::scan_pins_s    scan_in,
   input wire logic               cfg_busy,
   input wire logic [BSR_LEN-1:0] core_out,
   input scan_pkg::scan_drv_s     scan_out,
   input wire logic [BSR_LEN-1:0] pin_out,
   input wire logic               ext_mode,
   input wire logic               cfg_act,
   input wire logic               cfg_stb,
   input wire logic               la_act
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_quiet: assert property (
      $rose(rst_n) |-> !(ext_mode | cfg_act | la_act | cfg_stb | scan_out.tdo_oe))
      else $error("output active after reset");
   a_modes_onehot: assert property (
      $onehot0({ext_mode, cfg_act, la_act})) else $error("two modes at once");
   a_busy_blocks: assert property (
      $rose(ext_mode) |-> !$past(cfg_busy) && !$past(cfg_busy, 2))
      else $error("extest entered while busy");
   a_pin_follow: assert property (
      !ext_mode |=> pin_out == $past(core_out)) else $error("pins not core values");
   a_stb_pulse: assert property (
      cfg_stb |=> !cfg_stb) else $error("strobe longer than one clock");
   a_stb_cause: assert property (
      cfg_stb |-> cfg_act && $past(scan_in.tck, 2)) else $error("strobe without cause");
   a_trst_idle: assert property (
      !scan_in.trst_n [*6] |-> !scan_out.tdo_oe) else $error("tdo driven in reset");
   a_tdo_steady: assert property (
      $changed(scan_out) |=> $stable(scan_out) [*4]) else $error("tdo changed too soon");
   c_extest: cover property ($rose(ext_mode));
   c_cfg_bit: cover property (cfg_stb);
   c_analyzer: cover property ($rose(la_act));
endmodule
bind scan_port scan_port_chk #(.BSR_LEN(BSR_LEN)) u_chk (
   .clk(clk), .rst_n(rst_n), .scan_in(scan_in), .cfg_busy(cfg_busy),
   .core_out(core_out), .scan_out(scan_out), .pin_out(pin_out),
   .ext_mode(ext_mode), .cfg_act(cfg_act), .cfg_stb(cfg_stb), .la_act(la_act));

/* bench/tb_scan_port.sv */
// self-checking bench for the scan test port
`timescale 1ns/1ns
module tb_scan_port;
   localparam int BL = 8;
   logic                 clk = 1'b0, rst_n = 1'b0, cfg_busy = 1'b0;
   logic [BL-1:0]        pin_in = '0, core_out = '0, probe_in = '0, pin_out;
   logic [31:0]          user_code = '0;
   logic                 ext_mode, cfg_act, cfg_data, cfg_stb, la_act;
   logic                 big_ext, big_cfg, big_la;
   logic [63:0]          q, rx, d, pat;
   logic                 cfgq[$];
   int                   error_cnt = 0, n_tests = 0, cyc = 0;
   scan_pkg::scan_pins_s pins;
   scan_pkg::scan_drv_s  drv;
   scan_pkg::instr_t     ops[4] = '{scan_pkg::OP_BYPASS, 10'h155,
                                    scan_pkg::OP_EXTEST, scan_pkg::OP_SAMPLE};
   always #2 clk = ~clk;
   scan_port #(.BSR_LEN(BL), .PROBE_W(BL)) u_dut (
      .clk(clk), .rst_n(rst_n), .scan_in(pins), .cfg_busy(cfg_busy),
      .pin_in(pin_in), .core_out(core_out), .probe_in(probe_in),
      .user_code(user_code), .scan_out(drv), .pin_out(pin_out),
      .ext_mode(ext_mode), .cfg_act(cfg_act), .cfg_data(cfg_data),
      .cfg_stb(cfg_stb), .la_act(la_act));
   scan_port #(.BSR_LEN(BL), .PROBE_W(BL), .BYPASS_ONLY(1'b1)) u_dut_big (
      .clk(clk), .rst_n(rst_n), .scan_in(pins), .cfg_busy(cfg_busy),
      .pin_in(pin_in), .core_out(core_out), .probe_in(probe_in),
      .user_code(user_code), .scan_out(), .pin_out(),
      .ext_mode(big_ext), .cfg_act(big_cfg), .cfg_data(), .cfg_stb(),
      .la_act(big_la));
   scan_host u_host (.pins(pins), .tdo(drv.tdo), .tdo_oe(drv.tdo_oe));
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic ir(input scan_pkg::instr_t op);
      u_host.scan(1'b1, scan_pkg::IR_LEN, 64'(op), q);
      check("ir capture", q[9:0], scan_pkg::IR_CAPTURE);
   endtask
   task automatic dr(input int n, input logic [63:0] din);
      u_host.scan(1'b0, n, din, rx);
   endtask
   always @(posedge clk) begin
      if (cfg_stb === 1'b1) cfgq.push_back(cfg_data);
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(32'had8a));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      u_host.rst_pin(1'b1);
      u_host.to_idle();
      dr(32, {$urandom, $urandom});
      check("idcode", rx[31:0], scan_pkg::ID_CODE_DEF);
      user_code = $urandom;
      ir(scan_pkg::OP_USER);
      dr(32, 64'h0);
      check("usercode", rx[31:0], user_code);
      $display("test codes done");
      foreach (ops[i]) begin
         cfg_busy = (i >= 2);
         ir(ops[i]);
         d = 64'($urandom);
         dr(16, d);
         check("bypass", rx[15:0], {d[14:0], 1'b0});
         check("no extest", ext_mode, 1'b0);
      end
      cfg_busy = 1'b0;
      $display("test bypass done");
      pin_in = BL'($urandom);
      core_out = BL'($urandom);
      pat = 64'($urandom);
      ir(scan_pkg::OP_SAMPLE);
      dr(BL, pat);
      check("sample", rx[BL-1:0], pin_in);
      check("normal pins", pin_out, core_out);
      ir(scan_pkg::OP_EXTEST);
      check("preload", pin_out, pat[BL-1:0]);
      check("extest on", ext_mode, 1'b1);
      check("big extest", big_ext, 1'b0);
      pin_in = BL'($urandom);
      d = 64'($urandom);
      dr(BL, d);
      check("extest in", rx[BL-1:0], pin_in);
      check("extest out", pin_out, d[BL-1:0]);
      $display("test boundary done");
      ir(scan_pkg::OP_CFG);
      cfgq.delete();
      d = 64'($urandom);
      dr(12, d);
      check("cfg act", cfg_act, 1'b1);
      check("cfg out", rx[11:0], {d[10:0], 1'b0});
      check("big cfg", big_cfg, 1'b0);
      check("cfg bits", cfgq.size(), 12);
      foreach (cfgq[i]) check("cfg data", cfgq[i], d[i]);
      probe_in = BL'($urandom);
      pin_in = BL'($urandom);
      ir(scan_pkg::OP_ANALYZER);
      dr(2 * BL, 64'h0);
      check("analyzer", rx[2*BL-1:0], {probe_in, pin_in});
      check("la act", la_act, 1'b1);
      check("big la", big_la, 1'b1);
      $display("test cfg analyzer done");
      u_host.tick(1'b1, 1'b0, q[0]);
      u_host.tick(1'b0, 1'b0, q[0]);
      u_host.tick(1'b0, 1'b0, q[0]);
      repeat (4) @(negedge clk);
      check("shift oe", drv.tdo_oe, 1'b1);
      u_host.rst_pin(1'b0);
      repeat (10) @(negedge clk);
      check("trst oe", drv.tdo_oe, 1'b0);
      check("trst la", la_act, 1'b0);
      u_host.rst_pin(1'b1);
      repeat (4) @(negedge clk);
      u_host.tick(1'b0, 1'b0, q[0]);
      dr(32, {$urandom, $urandom});
      check("trst idcode", rx[31:0], scan_pkg::ID_CODE_DEF);
      $display("test trst done");
      print_verdict();
   end
endmodule

/* inc/scan_pkg.sv */
// shared types and constants for the scan test port
package scan_pkg;

   // ------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------
   localparam int IR_LEN = 10;
   typedef logic [IR_LEN-1:0] instr_t;

   localparam instr_t OP_EXTEST   = 10'h000;
   localparam instr_t OP_CFG      = 10'h002;
   localparam instr_t OP_SAMPLE   = 10'h005;
   localparam instr_t OP_ID       = 10'h006;
   localparam instr_t OP_USER     = 10'h007;
   localparam instr_t OP_ANALYZER = 10'h00e;
   localparam instr_t OP_BYPASS   = 10'h3ff;
   localparam instr_t IR_CAPTURE  = 10'h001;

   // ------------------------------------------------------------
   // code registers
   // ------------------------------------------------------------
   localparam int          CODE_LEN    = 32;
   // arbitrary value, lsb set as an identification register needs
   localparam logic [31:0] ID_CODE_DEF = 32'h0000_0001;

   // ------------------------------------------------------------
   // controller states and data paths
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_e;

   typedef enum logic [2:0] {
      PATH_BYP, PATH_BSR, PATH_CODE, PATH_CFG, PATH_LA
   } path_e;

   // ------------------------------------------------------------
   // pin groups
   // ------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } scan_pins_s;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } scan_drv_s;

endpackage

/* rtl/scan_port.sv */
// boundary-scan test access port with instruction decode and data registers
`timescale 1ns/1ns
// Functional notes
// - boundary scan blocked while configuration runs
// - sample captures pins, stages preload pattern
// - extest drives pattern, captures input pins
// - bypass is one stage, tdi to tdo
// - user code: 32 bits shifted out
// - identification register shifted out on tdo
// - configuration instructions stream bits inward
// - analyzer monitors probes via sample path
// - largest member: bypass and analyzer only
module scan_port #(
   parameter int          BSR_LEN     = 8,
   parameter int          PROBE_W     = 8,
   parameter bit          BYPASS_ONLY = 1'b0,
   parameter logic [31:0] ID_CODE     = scan_pkg::ID_CODE_DEF
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  scan_pkg::scan_pins_s      scan_in,
   input  wire logic                 cfg_busy,
   input  wire logic [BSR_LEN-1:0]   pin_in,
   input  wire logic [BSR_LEN-1:0]   core_out,
   input  wire logic [PROBE_W-1:0]   probe_in,
   input  wire logic [31:0]          user_code,
   output scan_pkg::scan_drv_s       scan_out,
   output logic      [BSR_LEN-1:0]   pin_out,
   output logic                      ext_mode,
   output logic                      cfg_act,
   output logic                      cfg_data,
   output logic                      cfg_stb,
   output logic                      la_act
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      scan_pkg::tap_e                  st;
      scan_pkg::instr_t                ir;
      scan_pkg::instr_t                ir_sh;
      logic [BSR_LEN-1:0]              bsr;
      logic [BSR_LEN-1:0]              upd;
      logic [PROBE_W-1:0]              probe_sh;
      logic [scan_pkg::CODE_LEN-1:0]   code_sh;
      logic                            byp;
      logic                            cfg_sh;
      logic                            tck_d;
      logic                            tdo;
      logic                            tdo_oe;
      logic [BSR_LEN-1:0]              pin_out;
      logic                            ext_mode;
      logic                            cfg_act;
      logic                            cfg_data;
      logic                            cfg_stb;
      logic                            la_act;
   } port_s;

   localparam scan_pkg::instr_t IR_RST =
      BYPASS_ONLY ? scan_pkg::OP_BYPASS : scan_pkg::OP_ID;

   port_s                 r;
   port_s                 n;
   scan_pkg::scan_pins_s  pins_s;
   logic [BSR_LEN-1:0]    pin_s;
   scan_pkg::path_e       path;
   logic                  rise;
   logic                  fall;
   logic                  allow_bs;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   sync2 #(
      .WIDTH ($bits(scan_pkg::scan_pins_s))
   ) u_sync_scan (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (scan_in),
      .q     (pins_s)
   );

   sync2 #(
      .WIDTH (BSR_LEN)
   ) u_sync_pins (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pin_in),
      .q     (pin_s)
   );

   // ------------------------------------------------------------
   // controller next state
   // ------------------------------------------------------------
   function automatic scan_pkg::tap_e tap_next(scan_pkg::tap_e s, logic tms);
      case (s)
         scan_pkg::TAP_RESET: tap_next = tms ? scan_pkg::TAP_RESET : scan_pkg::TAP_IDLE;
         scan_pkg::TAP_IDLE:  tap_next = tms ? scan_pkg::SEL_DR : scan_pkg::TAP_IDLE;
         scan_pkg::SEL_DR:    tap_next = tms ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
         scan_pkg::CAP_DR:    tap_next = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
         scan_pkg::SH_DR:     tap_next = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
         scan_pkg::EX1_DR:    tap_next = tms ? scan_pkg::UPD_DR : scan_pkg::PAU_DR;
         scan_pkg::PAU_DR:    tap_next = tms ? scan_pkg::EX2_DR : scan_pkg::PAU_DR;
         scan_pkg::EX2_DR:    tap_next = tms ? scan_pkg::UPD_DR : scan_pkg::SH_DR;
         scan_pkg::UPD_DR:    tap_next = tms ? scan_pkg::SEL_DR : scan_pkg::TAP_IDLE;
         scan_pkg::SEL_IR:    tap_next = tms ? scan_pkg::TAP_RESET : scan_pkg::CAP_IR;
         scan_pkg::CAP_IR:    tap_next = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
         scan_pkg::SH_IR:     tap_next = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
         scan_pkg::EX1_IR:    tap_next = tms ? scan_pkg::UPD_IR : scan_pkg::PAU_IR;
         scan_pkg::PAU_IR:    tap_next = tms ? scan_pkg::EX2_IR : scan_pkg::PAU_IR;
         scan_pkg::EX2_IR:    tap_next = tms ? scan_pkg::UPD_IR : scan_pkg::SH_IR;
         scan_pkg::UPD_IR:    tap_next = tms ? scan_pkg::SEL_DR : scan_pkg::TAP_IDLE;
         default:             tap_next = scan_pkg::TAP_RESET;
      endcase
   endfunction

   // ------------------------------------------------------------
   // instruction decode
   // ------------------------------------------------------------
   always_comb begin
      allow_bs = !BYPASS_ONLY && !cfg_busy;
      case (r.ir)
         scan_pkg::OP_EXTEST,
         scan_pkg::OP_SAMPLE:   path = allow_bs ? scan_pkg::PATH_BSR
                                                : scan_pkg::PATH_BYP;
         scan_pkg::OP_ID,
         scan_pkg::OP_USER:     path = BYPASS_ONLY ? scan_pkg::PATH_BYP
                                                   : scan_pkg::PATH_CODE;
         scan_pkg::OP_CFG:      path = BYPASS_ONLY ? scan_pkg::PATH_BYP
                                                   : scan_pkg::PATH_CFG;
         scan_pkg::OP_ANALYZER: path = scan_pkg::PATH_LA;
         default:               path = scan_pkg::PATH_BYP;
      endcase
   end

   // ------------------------------------------------------------
   // next value of all state
   // ------------------------------------------------------------
   always_comb begin
      n       = r;
      rise    = pins_s.tck & ~r.tck_d;
      fall    = ~pins_s.tck & r.tck_d;
      n.tck_d = pins_s.tck;
      n.cfg_stb = 1'b0;
      if (!pins_s.trst_n) begin
         n.st = scan_pkg::TAP_RESET;
         n.ir = IR_RST;
      end else if (rise) begin
         case (r.st)
            scan_pkg::TAP_RESET: begin
               n.ir = IR_RST;
            end
            scan_pkg::CAP_DR: begin
               case (path)
                  scan_pkg::PATH_BSR: n.bsr = pin_s;
                  scan_pkg::PATH_CODE: begin
                     n.code_sh = (r.ir == scan_pkg::OP_ID) ? ID_CODE : user_code;
                  end
                  scan_pkg::PATH_CFG: n.cfg_sh = cfg_busy;
                  scan_pkg::PATH_LA: begin
                     n.bsr      = pin_s;
                     n.probe_sh = probe_in;
                  end
                  default: n.byp = 1'b0;
               endcase
            end
            scan_pkg::SH_DR: begin
               case (path)
                  scan_pkg::PATH_BSR: n.bsr = {pins_s.tdi, r.bsr[BSR_LEN-1:1]};
                  scan_pkg::PATH_CODE: begin
                     n.code_sh = {pins_s.tdi, r.code_sh[scan_pkg::CODE_LEN-1:1]};
                  end
                  scan_pkg::PATH_CFG: begin
                     n.cfg_sh   = pins_s.tdi;
                     n.cfg_data = pins_s.tdi;
                     n.cfg_stb  = 1'b1;
                  end
                  scan_pkg::PATH_LA: begin
                     n.probe_sh = {pins_s.tdi, r.probe_sh[PROBE_W-1:1]};
                     n.bsr      = {r.probe_sh[0], r.bsr[BSR_LEN-1:1]};
                  end
                  default: n.byp = pins_s.tdi;
               endcase
            end
            scan_pkg::UPD_DR: begin
               if (path == scan_pkg::PATH_BSR) begin
                  n.upd = r.bsr;
               end
            end
            scan_pkg::CAP_IR: begin
               n.ir_sh = scan_pkg::IR_CAPTURE;
            end
            scan_pkg::SH_IR: begin
               n.ir_sh = {pins_s.tdi, r.ir_sh[scan_pkg::IR_LEN-1:1]};
            end
            scan_pkg::UPD_IR: begin
               n.ir = r.ir_sh;
            end
            default: begin
               n.ir = r.ir;
            end
         endcase
         n.st = tap_next(r.st, pins_s.tms);
      end
      // tdo changes on falling test clock, enabled only while shifting
      if (!pins_s.trst_n || r.st == scan_pkg::TAP_RESET) begin
         n.tdo_oe = 1'b0;
      end else if (fall) begin
         n.tdo_oe = (r.st == scan_pkg::SH_DR) || (r.st == scan_pkg::SH_IR);
         if (r.st == scan_pkg::SH_IR) begin
            n.tdo = r.ir_sh[0];
         end else begin
            case (path)
               scan_pkg::PATH_BSR,
               scan_pkg::PATH_LA:   n.tdo = r.bsr[0];
               scan_pkg::PATH_CODE: n.tdo = r.code_sh[0];
               scan_pkg::PATH_CFG:  n.tdo = r.cfg_sh;
               default:             n.tdo = r.byp;
            endcase
         end
      end
      n.ext_mode = (path == scan_pkg::PATH_BSR) && (r.ir == scan_pkg::OP_EXTEST);
      n.pin_out  = r.ext_mode ? r.upd : core_out;
      n.cfg_act  = (path == scan_pkg::PATH_CFG);
      n.la_act   = (path == scan_pkg::PATH_LA);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r    <= '0;
         r.st <= scan_pkg::TAP_RESET;
         r.ir <= IR_RST;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign scan_out        = {r.tdo, r.tdo_oe};
   assign pin_out         = r.pin_out;
   assign ext_mode        = r.ext_mode;
   assign cfg_act         = r.cfg_act;
   assign cfg_data        = r.cfg_data;
   assign cfg_stb         = r.cfg_stb;
   assign la_act          = r.la_act;

endmodule

/* rtl/sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_s;

   sync_s r;
   sync_s n;

   always_comb begin
      n    = r;
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;

endmodule
